/* src/ccs_regs.sv */
/*
 * CAN control/status registers: mode handshake, loopback, abort-all,
 * interrupt code, FIFO setup and flags/enables on classic Wishbone.
 * Assumes engine inputs are on clk_sys_i; bus pins are raw.
 */
// Our own choices: the register offsets and register access over Wishbone.
`timescale 1ns/10ps
module ccs_regs (
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    // Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [4:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Protocol engine
    input wire logic eng_tx_i,
    output logic eng_rx_o,
    input wire logic bus_bit_tick_i,
    input wire logic cpu_idle_i,
    input wire logic tx_all_aborted_i,
    input wire logic rx_msg_done_i,
    input wire logic [4:0] filter_hit_i,
    input wire logic [3:0] buffer_irq_i,
    input wire logic buffer_irq_valid_i,
    input wire logic [5:0] fifo_pointer_i,
    input wire logic [5:0] fifo_next_read_i,
    input wire ccs_pkg::ccs_err_s err_i,
    input wire ccs_pkg::ccs_evt_s evt_i,
    output logic halt_o,
    output logic abort_all_tx_o,
    output logic engine_off_o,
    output logic clear_err_cnt_o,
    output logic tx_en_o,
    output logic window_select_o,
    output logic capture_trig_o,
    // Bus pins
    input wire logic can_rx_i,
    output logic can_tx_o,
    output logic can_pins_own_o,
    // Interrupt request
    output logic irq_o
);
    logic stop_in_idle, abort_all_tx, rx_capture_enable, window_select;
    logic [2:0] mode_request, mode_current;
    logic [4:0] data_bit_compare_count, filter_hit_number;
    logic [2:0] dma_buffer_count;
    logic [4:0] fifo_start_buffer;
    logic [7:0] flags, enables;
    logic [6:0] interrupt_code;
    logic [2:0] rx_sync;
    logic rx_pin;
    logic [3:0] idle_cnt;
    logic err_prev;
    logic any_err, any_warning;
    logic wr, rd_ack, loop, cfg;
    logic [15:0] rdata;
    logic [7:0] set_vec;

    assign wr = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o;

    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            wb_ack_o <= 1'b0;
        end else begin
            wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
        end
    end

    // Pin synchroniser, change counted when stages two and three agree
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            rx_sync <= 3'h7;
            rx_pin <= 1'b1;
        end else begin
            rx_sync <= {rx_sync[1:0], can_rx_i};
            if (rx_sync[2] == rx_sync[1]) begin
                rx_pin <= rx_sync[2];
            end
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            idle_cnt <= 4'h0;
        end else if (bus_bit_tick_i) begin
            if (!rx_pin) begin
                idle_cnt <= 4'h0;
            end else if (idle_cnt != ccs_pkg::IDLE_BITS) begin
                idle_cnt <= idle_cnt + 4'h1;
            end
        end
    end

    // mode accepted only on idle bus
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            mode_current <= ccs_pkg::CCS_CONFIG;
        end else if (idle_cnt == ccs_pkg::IDLE_BITS &&
                     mode_request != 3'h5 && mode_request != 3'h6) begin
            mode_current <= mode_request;
        end
    end

    // Control one; reserved bit is not stored
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            stop_in_idle <= 1'b0;
            mode_request <= ccs_pkg::CCS_CONFIG;
            rx_capture_enable <= 1'b0;
            window_select <= 1'b0;
        end else if (wr && wb_adr_i == ccs_pkg::OFS_CTRL1) begin
            if (wb_sel_i[1]) begin
                stop_in_idle <= wb_dat_i[ccs_pkg::POS_SIDL];
                mode_request <= wb_dat_i[ccs_pkg::POS_REQ +: 3];
            end
            if (wb_sel_i[0]) begin
                rx_capture_enable <= wb_dat_i[ccs_pkg::POS_CAP];
                window_select <= wb_dat_i[ccs_pkg::POS_WSEL];
            end
        end
    end

    // abort bit cleared by hardware when done; completion wins
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            abort_all_tx <= 1'b0;
        end else if (abort_all_tx && tx_all_aborted_i) begin
            abort_all_tx <= 1'b0;
        end else if (wr && wb_adr_i == ccs_pkg::OFS_CTRL1 && wb_sel_i[1]) begin
            abort_all_tx <= wb_dat_i[ccs_pkg::POS_ABORT];
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            dma_buffer_count <= 3'h0;
            fifo_start_buffer <= 5'h00;
            data_bit_compare_count <= 5'h00;
        end else if (wr) begin
            if (wb_adr_i == ccs_pkg::OFS_FCTRL && wb_sel_i[1]) begin
                dma_buffer_count <= wb_dat_i[ccs_pkg::POS_DMACNT +: 3];
            end
            if (wb_adr_i == ccs_pkg::OFS_FCTRL && wb_sel_i[0]) begin
                fifo_start_buffer <= wb_dat_i[4:0];
            end
            // Invalid counts are refused so compare logic never overruns
            if (wb_adr_i == ccs_pkg::OFS_DCMP && wb_sel_i[0] &&
                wb_dat_i[4:0] <= ccs_pkg::DCMP_MAX) begin
                data_bit_compare_count <= wb_dat_i[4:0];
            end
        end
    end

    // filter hit latched per received message, except hits with bit 4 set
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            filter_hit_number <= 5'h00;
        end else if (rx_msg_done_i && !filter_hit_i[4]) begin
            filter_hit_number <= filter_hit_i;
        end
    end

    assign any_warning = err_i.tx_warning || err_i.rx_warning;
    assign any_err = |{err_i, any_warning};

    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            err_prev <= 1'b0;
        end else begin
            err_prev <= any_err;
        end
    end

    assign set_vec = {evt_i.invalid_msg, evt_i.wakeup, any_err && !err_prev,
                      1'b0, evt_i.fifo_almost_full, evt_i.rx_overflow,
                      evt_i.rx_buffer, evt_i.tx_buffer};

    // set wins over a zero write
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            flags <= 8'h00;
        end else if (wr && wb_adr_i == ccs_pkg::OFS_INTF && wb_sel_i[0]) begin
            flags <= ((flags & wb_dat_i[7:0]) | set_vec) & ccs_pkg::FLAG_MASK;
        end else begin
            flags <= (flags | set_vec) & ccs_pkg::FLAG_MASK;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            enables <= 8'h00;
        end else if (wr && wb_adr_i == ccs_pkg::OFS_INTE && wb_sel_i[0]) begin
            enables <= wb_dat_i[7:0] & ccs_pkg::FLAG_MASK;
        end
    end

    always_comb begin
        if (flags[5]) begin
            interrupt_code = ccs_pkg::CODE_ERR;
        end else if (flags[6]) begin
            interrupt_code = ccs_pkg::CODE_WAKE;
        end else if (flags[2]) begin
            interrupt_code = ccs_pkg::CODE_OVF;
        end else if (flags[3]) begin
            interrupt_code = ccs_pkg::CODE_FIFO;
        end else if (buffer_irq_valid_i && (flags[1] || flags[0])) begin
            interrupt_code = {3'h0, buffer_irq_i};
        end else begin
            interrupt_code = ccs_pkg::CODE_NONE;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            irq_o <= 1'b0;
        end else begin
            irq_o <= |(flags & enables);
        end
    end

    assign loop = mode_current == ccs_pkg::CCS_LOOP;
    assign cfg = mode_current == ccs_pkg::CCS_CONFIG;

    assign eng_rx_o = loop ? eng_tx_i : rx_pin;
    // pins released in loopback and disable; listen-only keeps the pins but transmits recessive
    assign can_pins_own_o = !(loop || mode_current == ccs_pkg::CCS_DISABLE);
    assign can_tx_o = (can_pins_own_o && tx_en_o) ? eng_tx_i : 1'b1;
    // no traffic in configuration, counters cleared
    assign engine_off_o = cfg || mode_current == ccs_pkg::CCS_DISABLE;
    assign clear_err_cnt_o = cfg;
    assign tx_en_o = !engine_off_o && mode_current != ccs_pkg::CCS_LISTEN &&
                     mode_current != ccs_pkg::CCS_LISTEN_ALL;
    assign halt_o = stop_in_idle && cpu_idle_i;
    assign abort_all_tx_o = abort_all_tx;
    assign window_select_o = window_select;
    assign capture_trig_o = rx_capture_enable && rx_msg_done_i;

    always_comb begin
        rdata = 16'h0000;
        unique case (wb_adr_i)
            ccs_pkg::OFS_CTRL1: rdata = {2'h0, stop_in_idle, abort_all_tx,
                1'b0, mode_request, mode_current, 1'b0, rx_capture_enable,
                2'h0, window_select};
            ccs_pkg::OFS_CTRL2: rdata = {11'h000, data_bit_compare_count};
            ccs_pkg::OFS_DCMP: rdata = {11'h000, data_bit_compare_count};
            ccs_pkg::OFS_VEC: rdata = {3'h0, filter_hit_number, 1'b0,
                interrupt_code};
            ccs_pkg::OFS_FCTRL: rdata = {dma_buffer_count, 8'h00,
                fifo_start_buffer};
            ccs_pkg::OFS_FIFO: rdata = {2'h0, fifo_pointer_i, 2'h0,
                fifo_next_read_i};
            ccs_pkg::OFS_INTF: rdata = {2'h0, err_i, any_warning, flags};
            ccs_pkg::OFS_INTE: rdata = {8'h00, enables};
            default: rdata = 16'h0000;
        endcase
    end

    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_dat_o <= {16'h0000, rdata};
        end
    end

    // One clock domain; checks pause while reset is held
    default clocking cb_sys @(posedge clk_sys_i);
    endclocking
    default disable iff (!rst_n_i);

    a_loop_path: assert property (loop |-> eng_rx_o == eng_tx_i)
        else $error("loopback broken");
    a_loop_pins: assert property (loop |-> !can_pins_own_o)
        else $error("pins not released");
    a_pins_idle: assert property (!can_pins_own_o |-> can_tx_o)
        else $error("released pin driven");
    a_mode_legal: assert property (mode_current != 3'h5 &&
        mode_current != 3'h6) else $error("reserved mode live");
    a_mode_idle: assert property ($changed(mode_current) |->
        $past(idle_cnt) == ccs_pkg::IDLE_BITS)
        else $error("mode change off idle");
    a_cfg_tx: assert property (cfg |-> !tx_en_o && clear_err_cnt_o)
        else $error("cfg traffic");

    a_halt_idle: assert property (halt_o |-> stop_in_idle && cpu_idle_i)
        else $error("bad halt");
    a_abort_clr: assert property (abort_all_tx && tx_all_aborted_i |=>
        !abort_all_tx) else $error("abort not cleared");
    a_abort_hold: assert property (abort_all_tx && !tx_all_aborted_i &&
        !wr |=> abort_all_tx) else $error("abort dropped");
    a_cap_trig: assert property (rx_msg_done_i && rx_capture_enable
        |-> capture_trig_o) else $error("capture missing");
    a_cap_quiet: assert property (!rx_capture_enable |-> !capture_trig_o)
        else $error("bad capture");
    a_dcmp_max: assert property (data_bit_compare_count <=
        ccs_pkg::DCMP_MAX) else $error("compare count invalid");
    a_hit_range: assert property (!filter_hit_number[4])
        else $error("reserved filter hit");
    a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack too long");

    a_err_code: assert property (flags[5] |->
        interrupt_code == ccs_pkg::CODE_ERR) else $error("bad code");
    a_code_none: assert property (!(|flags) |->
        interrupt_code == ccs_pkg::CODE_NONE) else $error("code not idle");
    a_err_set: assert property ($rose(any_err) |=> flags[5])
        else $error("error flag missed");
    a_flag_sticky: assert property (set_vec[0] |=> flags[0])
        else $error("flag set lost");
    a_flag_gap: assert property (!flags[4] && !enables[4])
        else $error("unused bit stored");
    a_irq_mask: assert property (!(|(flags & enables)) |=> !irq_o)
        else $error("masked irq");
    a_irq_gate: assert property (|(flags & enables) |=> irq_o)
        else $error("irq missing");

    c_loop: cover property (loop);
    c_abort: cover property (abort_all_tx ##1 !abort_all_tx);
    c_irq: cover property (irq_o);
    c_mode_move: cover property ($changed(mode_current));
    c_err_flag: cover property ($rose(flags[5]));
endmodule : ccs_regs

/* src/ccs_pkg.sv */
/*
 * Constants, register map and field layouts for the CAN control and
 * status register block. Assumes a 16-bit register file on Wishbone.
 */
package ccs_pkg;
    // Word offsets in byte addresses
    localparam logic [4:0] OFS_CTRL1 = 5'h00;
    localparam logic [4:0] OFS_CTRL2 = 5'h04;
    localparam logic [4:0] OFS_VEC = 5'h08;
    localparam logic [4:0] OFS_FCTRL = 5'h0c;
    localparam logic [4:0] OFS_FIFO = 5'h10;
    localparam logic [4:0] OFS_INTF = 5'h14;
    localparam logic [4:0] OFS_INTE = 5'h18;
    localparam logic [4:0] OFS_DCMP = 5'h1c;

    // Field positions
    localparam int POS_SIDL = 13;
    localparam int POS_ABORT = 12;
    localparam int POS_REQ = 8;
    localparam int POS_CUR = 5;
    localparam int POS_CAP = 3;
    localparam int POS_WSEL = 0;
    localparam int POS_FHIT = 8;
    localparam int POS_DMACNT = 13;
    localparam int POS_FPTR = 8;

    // Interrupt codes, limits and masks
    localparam logic [6:0] CODE_NONE = 7'h40;
    localparam logic [6:0] CODE_ERR = 7'h41;
    localparam logic [6:0] CODE_WAKE = 7'h42;
    localparam logic [6:0] CODE_OVF = 7'h43;
    localparam logic [6:0] CODE_FIFO = 7'h44;
    localparam logic [4:0] DCMP_MAX = 5'h11;
    localparam logic [7:0] FLAG_MASK = 8'hef;
    localparam logic [3:0] IDLE_BITS = 4'hb;

    typedef enum logic [2:0] {
        CCS_NORMAL = 3'h0,
        CCS_DISABLE = 3'h1,
        CCS_LOOP = 3'h2,
        CCS_LISTEN = 3'h3,
        CCS_CONFIG = 3'h4,
        CCS_LISTEN_ALL = 3'h7
    } ccs_mode_e;

    // Error state inputs from the protocol engine
    typedef struct packed {
        logic tx_bus_off;
        logic tx_error_passive;
        logic rx_error_passive;
        logic tx_warning;
        logic rx_warning;
    } ccs_err_s;

    // One-cycle event pulses, flag bit order
    typedef struct packed {
        logic invalid_msg;
        logic wakeup;
        logic fifo_almost_full;
        logic rx_overflow;
        logic rx_buffer;
        logic tx_buffer;
    } ccs_evt_s;
endpackage : ccs_pkg

/* tb/ccs_can_node.sv */
/*
 * Far-side model: a second CAN node on the shared wired-and bus.
 * Assumes the bench raises talk_i to hold the bus dominant.
 */
`timescale 1ns/10ps
module ccs_can_node (
    // Clock
    input wire logic clk_sys_i,
    // Device pins
    input wire logic dut_tx_i,
    input wire logic dut_own_i,
    // Bench control and bus level
    input wire logic talk_i,
    output logic bus_o
);
    logic node_tx = 1'b1;
    always_ff @(posedge clk_sys_i) begin
        node_tx <= !talk_i;
    end
    assign bus_o = node_tx & (dut_own_i ? dut_tx_i : 1'b1);
endmodule : ccs_can_node

/* tb/tb_top.sv */
/*
 * Self-checking bench for ccs_regs with a Wishbone master and engine stubs.
 * Assumes a second node on the bus and a one-cycle registered ack.
 */
`timescale 1ns/10ps
module tb_top;
    localparam logic [4:0] A_C1 = ccs_pkg::OFS_CTRL1;
    localparam logic [4:0] A_VEC = ccs_pkg::OFS_VEC;
    localparam logic [4:0] A_IF = ccs_pkg::OFS_INTF;
    localparam logic [4:0] A_IE = ccs_pkg::OFS_INTE;
    logic clk_sys_i = 1'b0, rst_n_i = 1'b0, talk = 1'b0;
    logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
    logic [4:0] wb_adr_i = 5'h00, filter_hit_i = 5'h00;
    logic [31:0] wb_dat_i = 32'h0, wb_dat_o, seed = 32'h92aae7d0, r;
    logic wb_ack_o, eng_rx_o, halt_o, abort_all_tx_o, engine_off_o, irq_o;
    logic clear_err_cnt_o, tx_en_o, window_select_o, capture_trig_o;
    logic can_rx_i, can_tx_o, can_pins_own_o, buffer_irq_valid_i = 1'b0;
    logic eng_tx_i = 1'b1, bus_bit_tick_i = 1'b0, cpu_idle_i = 1'b0;
    logic tx_all_aborted_i = 1'b0, rx_msg_done_i = 1'b0;
    logic [3:0] buffer_irq_i = 4'h0, wb_sel_i = 4'h0;
    logic [5:0] fifo_pointer_i = 6'h00, fifo_next_read_i = 6'h00;
    ccs_pkg::ccs_err_s err_i = '0;
    ccs_pkg::ccs_evt_s evt_i = '0;
    ccs_pkg::ccs_evt_s ev [3] = '{6'h10, 6'h04, 6'h08};
    logic [6:0] ic [3] = '{7'h42, 7'h43, 7'h44};
    logic [2:0] modes [7] = '{3'h2, 3'h5, 3'h1, 3'h3, 3'h7, 3'h4, 3'h0};
    logic [4:0] dn [5] = '{5'h11, 5'h12, 5'h00, 5'h1f, 5'h01};
    logic [15:0] exp_q [$], msk_q [$], e, me, mk;
    logic [2:0] cur;
    logic [7:0] fl;
    int bad_count = 0, total_checks = 0, b;

    initial forever #4 clk_sys_i = ~clk_sys_i;
    ccs_regs i_dut (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
        .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
        .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .eng_tx_i(eng_tx_i),
        .eng_rx_o(eng_rx_o), .bus_bit_tick_i(bus_bit_tick_i),
        .cpu_idle_i(cpu_idle_i), .tx_all_aborted_i(tx_all_aborted_i),
        .rx_msg_done_i(rx_msg_done_i), .filter_hit_i(filter_hit_i),
        .buffer_irq_i(buffer_irq_i), .buffer_irq_valid_i(buffer_irq_valid_i),
        .fifo_pointer_i(fifo_pointer_i), .fifo_next_read_i(fifo_next_read_i),
        .err_i(err_i), .evt_i(evt_i), .halt_o(halt_o),
        .abort_all_tx_o(abort_all_tx_o), .engine_off_o(engine_off_o),
        .clear_err_cnt_o(clear_err_cnt_o), .tx_en_o(tx_en_o),
        .window_select_o(window_select_o), .capture_trig_o(capture_trig_o),
        .can_rx_i(can_rx_i), .can_tx_o(can_tx_o),
        .can_pins_own_o(can_pins_own_o), .irq_o(irq_o));
    ccs_can_node i_node (.clk_sys_i(clk_sys_i), .dut_tx_i(can_tx_o),
        .dut_own_i(can_pins_own_o), .talk_i(talk), .bus_o(can_rx_i));

    function logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : rnd
    // Control word from request, current mode and {idle, abort, cap, win}
    function logic [15:0] c1(input logic [2:0] q, c, input logic [3:0] f);
        return {2'b00, f[3:2], 1'b0, q, c, 1'b0, f[1], 2'b00, f[0]};
    endfunction : c1
    task automatic fail(input string s);
        bad_count++;
        $display("BAD %0t %s", $time, s);
    endtask : fail
    task automatic chk(input logic g, input logic x, input string s);
        total_checks++;
        if (g !== x) fail(s);
    endtask : chk
    task automatic settle(input int n);
        repeat (n) @(posedge clk_sys_i);
        #1;
    endtask : settle
    task automatic wb(input logic we, input logic [4:0] a,
                      input logic [15:0] d);
        int n;
        n = 0;
        @(posedge clk_sys_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_sel_i <= 4'h3;
        wb_adr_i <= a;
        wb_dat_i <= {16'h0000, d};
        do begin
            @(posedge clk_sys_i);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 16);
        if (n >= 16) fail("no ack");
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i <= 1'b0;
        wb_sel_i <= 4'h0;
    endtask : wb
    task automatic rd(input logic [4:0] a, input logic [15:0] x, k);
        exp_q.push_back(x);
        msk_q.push_back(k);
        wb(1'b0, a, 16'h0000);
    endtask : rd
    // Bit ticks spaced four cycles apart
    task automatic tick(input int n);
        repeat (n) begin
            @(posedge clk_sys_i);
            bus_bit_tick_i <= 1'b1;
            @(posedge clk_sys_i);
            bus_bit_tick_i <= 1'b0;
            repeat (2) @(posedge clk_sys_i);
        end
    endtask : tick
    task automatic pulse(input ccs_pkg::ccs_evt_s v);
        @(posedge clk_sys_i);
        evt_i <= v;
        @(posedge clk_sys_i);
        evt_i <= '0;
    endtask : pulse
    task automatic results();
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : results

    // Read monitor: oldest note against data on the ack edge
    always @(posedge clk_sys_i) begin
        if (wb_ack_o === 1'b1 && wb_we_i === 1'b0) begin
            if (exp_q.size() == 0) fail("unexpected read");
            else begin
                me = exp_q.pop_front();
                mk = msk_q.pop_front();
                total_checks++;
                if ((wb_dat_o & {16'hffff, mk}) !== {16'h0000, me & mk})
                    fail("read data");
            end
        end
    end

    initial begin
        #100000;
        fail("timeout");
        results();
    end

    initial begin
        repeat (12) @(posedge clk_sys_i);
        rst_n_i <= 1'b1;
        rd(A_C1, 16'h0480, 16'hffff);
        rd(A_VEC, 16'h0040, 16'hffff);
        rd(A_IF, 16'h0000, 16'hffff);
        rd(A_IE, 16'h0000, 16'hffff);
        rd(5'h1e, 16'h0000, 16'hffff);
        $display("test reset done");
        cur = 3'h4;
        foreach (modes[i]) begin
            @(posedge clk_sys_i);
            talk <= 1'b1;
            repeat (8) @(posedge clk_sys_i);
            tick(1);
            wb(1'b1, A_C1, c1(modes[i], 3'h0, 4'h0));
            @(posedge clk_sys_i);
            talk <= 1'b0;
            repeat (8) @(posedge clk_sys_i);
            tick(10);
            rd(A_C1, {8'h00, cur, 5'h00}, 16'h00e0);
            tick(2);
            if (modes[i] != 3'h5) cur = modes[i];
            rd(A_C1, {8'h00, cur, 5'h00}, 16'h00e0);
            settle(1);
            chk(can_pins_own_o, !(cur inside {3'h1, 3'h2}), "pins");
            chk(clear_err_cnt_o, cur == 3'h4, "err clear");
            chk(engine_off_o, cur inside {3'h1, 3'h4}, "engine off");
            if (cur inside {3'h0, 3'h4}) chk(tx_en_o, cur == 3'h0, "tx");
            if (cur == 3'h2) repeat (4) begin
                @(posedge clk_sys_i);
                r = rnd();
                eng_tx_i <= r[0];
                settle(0);
                chk(eng_rx_o, eng_tx_i, "loopback");
            end
            @(posedge clk_sys_i);
            eng_tx_i <= 1'b1;
        end
        $display("test modes done");
        wb(1'b1, A_C1, c1(3'h0, 3'h0, 4'hb));
        rd(A_C1, c1(3'h0, 3'h0, 4'hb), 16'hffff);
        settle(0);
        chk(window_select_o, 1'b1, "window");
        repeat (4) begin
            @(posedge clk_sys_i);
            r = rnd();
            cpu_idle_i <= r[0];
            settle(0);
            chk(halt_o, cpu_idle_i, "halt");
        end
        @(posedge clk_sys_i);
        rx_msg_done_i <= 1'b1;
        filter_hit_i <= 5'h09;
        settle(0);
        chk(capture_trig_o, 1'b1, "capture");
        @(posedge clk_sys_i);
        rx_msg_done_i <= 1'b0;
        rd(A_VEC, 16'h0900, 16'h1f00);
        wb(1'b1, A_C1, c1(3'h0, 3'h0, 4'h4));
        rd(A_C1, c1(3'h0, 3'h0, 4'h4), 16'hffff);
        settle(0);
        chk(abort_all_tx_o, 1'b1, "abort");
        chk(window_select_o, 1'b0, "window");
        chk(halt_o, 1'b0, "no halt");
        @(posedge clk_sys_i);
        rx_msg_done_i <= 1'b1;
        filter_hit_i <= 5'h10;
        settle(0);
        chk(capture_trig_o, 1'b0, "no capture");
        @(posedge clk_sys_i);
        rx_msg_done_i <= 1'b0;
        tx_all_aborted_i <= 1'b1;
        @(posedge clk_sys_i);
        tx_all_aborted_i <= 1'b0;
        rd(A_C1, c1(3'h0, 3'h0, 4'h0), 16'hffff);
        rd(A_VEC, 16'h0900, 16'h1f00);
        $display("test control done");
        e = 16'h0000;
        foreach (dn[i]) begin
            wb(1'b1, ccs_pkg::OFS_DCMP, {11'h000, dn[i]});
            if (dn[i] <= ccs_pkg::DCMP_MAX) e = {11'h000, dn[i]};
            rd(ccs_pkg::OFS_CTRL2, e, 16'hffff);
        end
        repeat (4) begin
            r = rnd();
            e = r[15:0] & 16'he01f;
            if (e[15:13] == 3'h7) e[15] = 1'b0;
            wb(1'b1, ccs_pkg::OFS_FCTRL, e | 16'h1fe0);
            rd(ccs_pkg::OFS_FCTRL, e, 16'hffff);
            @(posedge clk_sys_i);
            fifo_pointer_i <= {1'b0, r[20:16]};
            fifo_next_read_i <= {1'b0, r[28:24]};
            rd(ccs_pkg::OFS_FIFO, {3'h0, r[20:16], 3'h0, r[28:24]},
               16'hffff);
        end
        $display("test fifo done");
        wb(1'b1, A_IE, 16'hffff);
        rd(A_IE, 16'h00ef, 16'hffff);
        @(posedge clk_sys_i);
        err_i <= 5'h01;
        rd(A_IF, 16'h0020, 16'h0020);
        repeat (4) begin
            r = rnd();
            @(posedge clk_sys_i);
            err_i <= r[4:0];
            settle(4);
            rd(A_IF, {2'b00, r[4:0], r[1] | r[0], 8'h00}, 16'h3f00);
        end
        pulse('1);
        wb(1'b1, A_IF, 16'hffff);
        rd(A_IF, 16'h00ef, 16'h00ff);
        fl = 8'hef;
        for (b = 0; b < 8; b++) if (ccs_pkg::FLAG_MASK[b]) begin
            wb(1'b1, A_IE, 16'h0001 << b);
            settle(2);
            chk(irq_o, 1'b1, "irq on");
            fl[b] = 1'b0;
            wb(1'b1, A_IF, {8'h00, fl});
            settle(2);
            chk(irq_o, 1'b0, "irq off");
            rd(A_IF, {8'h00, fl}, 16'h00ff);
        end
        $display("test flags done");
        wb(1'b1, A_IE, 16'h00ef);
        foreach (ic[i]) begin
            pulse(ev[i]);
            rd(A_VEC, {9'h000, ic[i]}, 16'h007f);
            wb(1'b1, A_IF, 16'h0000);
        end
        @(posedge clk_sys_i);
        err_i <= 5'h00;
        @(posedge clk_sys_i);
        err_i <= 5'h04;
        pulse(ev[0]);
        rd(A_VEC, {9'h000, ccs_pkg::CODE_ERR}, 16'h007f);
        @(posedge clk_sys_i);
        buffer_irq_i <= 4'h5;
        buffer_irq_valid_i <= 1'b1;
        wb(1'b1, A_IF, 16'h0000);
        pulse(6'h02);
        rd(A_VEC, 16'h0005, 16'h007f);
        @(posedge clk_sys_i);
        buffer_irq_valid_i <= 1'b0;
        rd(A_VEC, {9'h000, ccs_pkg::CODE_NONE}, 16'h007f);
        $display("test code done");
        results();
    end
endmodule : tb_top
